// ===== hdl/hms_host_if.sv
`timescale 1ns/1ps
// Operation
// R01: with step_dir_select low the ramp generator runs the motor.
// R02: with step_dir_select high the motor follows the step and dir pins.
// R03: serial_config_select low and step_dir_select high give pin-only mode.
// R04: link_type_select chooses the spi port or the single-wire uart port.
// R05: spi shifts on the master clock and returns one bit per bit received.
// R06: each spi transaction is one 40-bit command and one 40-bit status.
// R07: uart frames carry a crc that the device checks and the host appends.
// R08: the uart finds the bit time of incoming traffic on its own.
// R09: the uart line is differential on wire_pos/wire_neg or single-ended.
// R10: commands are tagged as write or read so registers can be one-way.
// R11: a host wanting read-modify-write keeps a shadow of one-way registers.
// R12: in step/dir operation the internal motion controller is unused.
// R13: rising step edges are active, or both edges with dual_edge_step.
// R14: dir low counts the microstep counter up, high counts it down.
// R15: spi frames are bounded by chip select; partial frames are dropped.
// R16: mode and link straps are taken once after reset and then held.
module hms_host_if
   import hms_pkg::*;
#(
   parameter logic LINK_UART_LEVEL = 1'b1,
   parameter int   FRAME_BYTES     = UART_FRAME_BYTES
) (
   input  wire logic                      clk_sys,
   input  wire logic                      rst_n,
   input  wire logic                      step_dir_select,
   input  wire logic                      serial_config_select,
   input  wire logic                      link_type_select,
   input  wire logic                      spi_sclk,
   input  wire logic                      spi_cs_n,
   input  wire logic                      spi_mosi,
   output logic                           spi_miso,
   output logic                           spi_miso_oe,
   input  wire logic                      wire_pos,
   input  wire logic                      wire_neg,
   input  wire logic                      uart_diff_mode,
   input  wire logic                      step_in,
   input  wire logic                      dir_in,
   input  wire logic                      dual_edge_step,
   input  wire logic [3:0]                mres,
   input  wire logic [SPI_WORD_BITS-1:0]  status_word,
   output logic                           cfg_valid,
   output hms_mode_t                      mode_sel,
   output logic                           link_is_uart,
   output logic                           ramp_gen_en,
   output logic                           step_dir_en,
   output logic                           pin_config_en,
   output logic                           host_if_en,
   output logic                           cmd_valid,
   output logic                           cmd_is_write,
   output logic [SPI_WORD_BITS-1:0]       cmd_word,
   output logic                           spi_frame_err,
   output logic                           uart_frame_valid,
   output logic [8*(FRAME_BYTES-1)-1:0]   uart_frame_data,
   output logic                           uart_crc_err,
   output logic [BAUD_W-1:0]              uart_baud_len,
   output logic [MSTEP_W-1:0]             mstep_count
);

   logic [PIN_COUNT-1:0]     pin_meta_r;
   logic [PIN_COUNT-1:0]     pin_s_r;
   logic [PIN_COUNT-1:0]     pin_d_r;
   logic [1:0]               cfg_cnt_r;
   logic                     cfg_done_r;
   hms_mode_t                mode_r;
   logic                     uart_sel_r;
   logic [SPI_CNT_W-1:0]     bit_cnt_r;
   logic [SPI_WORD_BITS-1:0] rx_sh_r;
   logic [SPI_WORD_BITS-1:0] tx_sh_r;
   logic [SPI_WORD_BITS-1:0] cmd_word_r;
   logic                     cmd_valid_r;
   logic                     cmd_wr_r;
   logic                     frame_err_r;
   logic [MSTEP_W-1:0]       mstep_r;
   logic                     sclk_rise;
   logic                     sclk_fall;
   logic                     cs_fall;
   logic                     cs_rise;
   logic                     cs_act;
   logic                     spi_act;
   logic                     uart_act;
   logic                     step_edge;
   logic                     step_act;
   logic                     rx_level;
   logic [3:0]               mres_c;
   logic [MSTEP_W-1:0]       mstep_inc;

   // every pin passes two flops; edge logic compares the second with a third delay flop
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_meta_r <= '0;
         pin_s_r    <= '0;
         pin_d_r    <= '0;
      end else begin
         pin_meta_r <= {dir_in, step_in, wire_neg, wire_pos, spi_mosi,
                        spi_cs_n, spi_sclk, link_type_select,
                        serial_config_select, step_dir_select};
         pin_s_r    <= pin_meta_r;
         pin_d_r    <= pin_s_r;
      end
   end

   // straps are caught once the synchroniser has filled, then frozen
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cfg_cnt_r  <= 2'h0;
         cfg_done_r <= 1'b0;
         mode_r     <= HMS_MODE_MOTION;
         uart_sel_r <= 1'b0;
      end else if (!cfg_done_r) begin
         cfg_cnt_r <= cfg_cnt_r + 2'h1;
         if (cfg_cnt_r == CFG_SETTLE) begin
            cfg_done_r <= 1'b1; // [R16]
            uart_sel_r <= (pin_s_r[PIN_LINK_SEL] == LINK_UART_LEVEL); // [R04]
            if (!pin_s_r[PIN_SD_SEL]) begin
               mode_r <= HMS_MODE_MOTION; // [R01]
            end else if (!pin_s_r[PIN_CFG_SEL]) begin
               mode_r <= HMS_MODE_STANDALONE; // [R03]
            end else begin
               mode_r <= HMS_MODE_STEPDIR; // [R02]
            end
         end
      end
   end

   assign cfg_valid     = cfg_done_r;
   assign mode_sel      = mode_r;
   assign link_is_uart  = uart_sel_r;
   assign ramp_gen_en   = cfg_done_r & (mode_r == HMS_MODE_MOTION); // [R12]
   assign step_dir_en   = step_act;
   assign pin_config_en = cfg_done_r & (mode_r == HMS_MODE_STANDALONE);
   // pin-only mode ignores both host ports
   assign host_if_en    = cfg_done_r & (mode_r != HMS_MODE_STANDALONE); // [R03]
   assign spi_act       = host_if_en & ~uart_sel_r; // [R04]
   assign uart_act      = host_if_en & uart_sel_r; // [R04]

   assign sclk_rise = pin_s_r[PIN_SCLK] & ~pin_d_r[PIN_SCLK];
   assign sclk_fall = ~pin_s_r[PIN_SCLK] & pin_d_r[PIN_SCLK];
   assign cs_fall   = ~pin_s_r[PIN_CS_N] & pin_d_r[PIN_CS_N];
   assign cs_rise   = pin_s_r[PIN_CS_N] & ~pin_d_r[PIN_CS_N];
   assign cs_act    = ~pin_s_r[PIN_CS_N];

   // mode 3 style: sample on rising sclk, shift out on falling sclk.
   // the synchroniser costs about three cycles, so sclk must stay well
   // below a quarter of clk_sys
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bit_cnt_r   <= '0;
         rx_sh_r     <= '0;
         tx_sh_r     <= '0;
         cmd_word_r  <= '0;
         cmd_valid_r <= 1'b0;
         cmd_wr_r    <= 1'b0;
         frame_err_r <= 1'b0;
      end else begin
         cmd_valid_r <= 1'b0;
         frame_err_r <= 1'b0;
         if (!spi_act) begin
            bit_cnt_r <= '0;
         end else if (cs_fall) begin
            bit_cnt_r <= '0;
            tx_sh_r   <= status_word; // [R06]
         end else if (cs_rise) begin
            bit_cnt_r <= '0;
            if (bit_cnt_r == SPI_BITS_FULL) begin
               cmd_word_r  <= rx_sh_r; // [R15]
               cmd_wr_r    <= rx_sh_r[SPI_WR_BIT]; // [R10]
               cmd_valid_r <= 1'b1; // [R06]
            end else if (bit_cnt_r != '0) begin
               frame_err_r <= 1'b1; // [R15]
            end
         end else if (cs_act) begin
            if (sclk_rise) begin
               rx_sh_r <= {rx_sh_r[SPI_WORD_BITS-2:0],
                           pin_s_r[PIN_MOSI]}; // [R05]
               // saturates one past full so over-long frames are refused
               if (bit_cnt_r <= SPI_BITS_FULL) begin
                  bit_cnt_r <= bit_cnt_r + 6'h01;
               end
            end
            if (sclk_fall && bit_cnt_r != '0) begin
               tx_sh_r <= {tx_sh_r[SPI_WORD_BITS-2:0], 1'b0}; // [R05]
            end
         end
      end
   end

   assign spi_miso      = tx_sh_r[SPI_WORD_BITS-1];
   assign spi_miso_oe   = spi_act & cs_act;
   assign cmd_valid     = cmd_valid_r;
   assign cmd_is_write  = cmd_wr_r;
   assign cmd_word      = cmd_word_r;
   assign spi_frame_err = frame_err_r;

   // differential: low only when wire_neg is above wire_pos
   assign rx_level = uart_diff_mode
                   ? (pin_s_r[PIN_WIRE_POS] | ~pin_s_r[PIN_WIRE_NEG]) // [R09]
                   : pin_s_r[PIN_WIRE_POS]; // [R09]

   hms_uart_rx #(
      .FRAME_BYTES (FRAME_BYTES)
   ) u_uart_rx (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .rx_enable   (uart_act),
      .rx_level    (rx_level),
      .frame_valid (uart_frame_valid),
      .frame_data  (uart_frame_data),
      .crc_err     (uart_crc_err),
      .baud_len    (uart_baud_len)
   );

   // step/dir path; motion mode ignores the step pin entirely
   assign step_act  = cfg_done_r & (mode_r != HMS_MODE_MOTION); // [R12]
   assign step_edge = (pin_s_r[PIN_STEP] & ~pin_d_r[PIN_STEP])
                    | (dual_edge_step & ~pin_s_r[PIN_STEP]
                       & pin_d_r[PIN_STEP]); // [R13]
   assign mres_c    = (mres > MRES_MAX) ? MRES_MAX : mres;
   assign mstep_inc = MSTEP_W'(1) << mres_c;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         mstep_r <= MSTEP_RST;
      end else if (step_act && step_edge) begin
         if (!pin_s_r[PIN_DIR]) begin
            mstep_r <= mstep_r + mstep_inc; // [R14]
         end else begin
            mstep_r <= mstep_r - mstep_inc; // [R14]
         end
      end
   end

   assign mstep_count = mstep_r;

endmodule : hms_host_if

// ===== hdl/hms_pkg.sv
package hms_pkg;

   // spi framing
   localparam int          SPI_WORD_BITS = 40;
   localparam int          SPI_CNT_W     = 6;
   localparam logic [5:0]  SPI_BITS_FULL = 6'h28;
   localparam int          SPI_WR_BIT    = 39;

   // positions inside the pin synchroniser vector
   localparam int          PIN_SD_SEL    = 0;
   localparam int          PIN_CFG_SEL   = 1;
   localparam int          PIN_LINK_SEL  = 2;
   localparam int          PIN_SCLK      = 3;
   localparam int          PIN_CS_N      = 4;
   localparam int          PIN_MOSI      = 5;
   localparam int          PIN_WIRE_POS  = 6;
   localparam int          PIN_WIRE_NEG  = 7;
   localparam int          PIN_STEP      = 8;
   localparam int          PIN_DIR       = 9;
   localparam int          PIN_COUNT     = 10;

   // cycles after reset release before the straps are trusted
   localparam logic [1:0]  CFG_SETTLE    = 2'h3;

   // microstep counter
   localparam int          MSTEP_W       = 10;
   localparam logic [9:0]  MSTEP_RST     = 10'h000;
   localparam logic [3:0]  MRES_MAX      = 4'h8;

   // single-wire uart
   localparam int          UART_FRAME_BYTES = 8;
   localparam int          BAUD_W           = 16;
   localparam logic [15:0] BAUD_MIN         = 16'h0004;
   localparam logic [5:0]  UART_GAP_BITS    = 6'h20;
   localparam logic [7:0]  CRC_POLY         = 8'h07;
   localparam logic [7:0]  CRC_INIT         = 8'h00;

   typedef enum logic [1:0] {
      HMS_MODE_MOTION     = 2'b00,
      HMS_MODE_STEPDIR    = 2'b01,
      HMS_MODE_STANDALONE = 2'b10
   } hms_mode_t;

   typedef enum logic [2:0] {
      URX_IDLE    = 3'b000,
      URX_MEASURE = 3'b001,
      URX_START   = 3'b010,
      URX_DATA    = 3'b011,
      URX_STOP    = 3'b100
   } hms_urx_state_t;

   // bytes enter lsb first, polynomial x^8+x^2+x+1
   function automatic logic [7:0] hms_crc8_step(input logic [7:0] crc,
                                                input logic [7:0] data);
      logic [7:0] c;
      c = crc;
      for (int i = 0; i < 8; i++) begin
         if (c[7] ^ data[i]) begin
            c = {c[6:0], 1'b0} ^ CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction : hms_crc8_step

endpackage : hms_pkg

// ===== hdl/hms_uart_rx.sv
`timescale 1ns/1ps
module hms_uart_rx
   import hms_pkg::*;
#(
   parameter int FRAME_BYTES = UART_FRAME_BYTES
) (
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   input  wire logic                       rx_enable,
   input  wire logic                       rx_level,
   output logic                            frame_valid,
   output logic [8*(FRAME_BYTES-1)-1:0]    frame_data,
   output logic                            crc_err,
   output logic [BAUD_W-1:0]               baud_len
);

   localparam int DW = 8*(FRAME_BYTES-1);

   hms_urx_state_t    state_r;
   logic [BAUD_W-1:0] cnt_r;
   logic [BAUD_W-1:0] bit_len_r;
   logic [2:0]        bit_idx_r;
   logic [7:0]        shift_r;
   logic [3:0]        byte_idx_r;
   logic [7:0]        crc_r;
   logic [5:0]        gap_r;
   logic [DW-1:0]     data_r;
   logic              valid_r;
   logic              err_r;
   logic              bit_end;

   assign bit_end     = (cnt_r == bit_len_r - 16'h0001);
   assign frame_valid = valid_r;
   assign frame_data  = data_r;
   assign crc_err     = err_r;
   assign baud_len    = bit_len_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_r    <= URX_IDLE;
         cnt_r      <= '0;
         bit_len_r  <= BAUD_MIN;
         bit_idx_r  <= 3'h0;
         shift_r    <= 8'h00;
         byte_idx_r <= 4'h0;
         crc_r      <= CRC_INIT;
         gap_r      <= 6'h00;
         data_r     <= '0;
         valid_r    <= 1'b0;
         err_r      <= 1'b0;
      end else begin
         valid_r <= 1'b0;
         err_r   <= 1'b0;
         if (!rx_enable) begin
            state_r    <= URX_IDLE;
            byte_idx_r <= 4'h0;
            crc_r      <= CRC_INIT;
         end else begin
            case (state_r)
               URX_IDLE: begin
                  if (!rx_level) begin
                     cnt_r   <= 16'h0001;
                     gap_r   <= 6'h00;
                     // first byte of a frame re-measures the bit time [R08]
                     state_r <= (byte_idx_r == 4'h0) ? URX_MEASURE
                                                     : URX_START;
                  end else if (byte_idx_r != 4'h0) begin
                     // a long quiet line drops a half-received frame
                     if (bit_end) begin
                        cnt_r <= '0;
                        gap_r <= gap_r + 6'h01;
                        if (gap_r == UART_GAP_BITS - 6'h01) begin
                           byte_idx_r <= 4'h0;
                           crc_r      <= CRC_INIT;
                        end
                     end else begin
                        cnt_r <= cnt_r + 16'h0001;
                     end
                  end
               end
               URX_MEASURE: begin
                  // sync byte has lsb set: the low run is one start bit
                  if (rx_level) begin
                     if (cnt_r < BAUD_MIN) begin
                        state_r <= URX_IDLE;
                     end else begin
                        bit_len_r <= cnt_r; // [R08]
                        cnt_r     <= cnt_r >> 1;
                        bit_idx_r <= 3'h0;
                        state_r   <= URX_DATA;
                     end
                  end else if (cnt_r == {BAUD_W{1'b1}}) begin
                     state_r <= URX_IDLE;
                  end else begin
                     cnt_r <= cnt_r + 16'h0001;
                  end
               end
               URX_START: begin
                  if (cnt_r == (bit_len_r >> 1)) begin
                     cnt_r     <= '0;
                     bit_idx_r <= 3'h0;
                     state_r   <= rx_level ? URX_IDLE : URX_DATA;
                  end else begin
                     cnt_r <= cnt_r + 16'h0001;
                  end
               end
               URX_DATA: begin
                  if (bit_end) begin
                     cnt_r   <= '0;
                     shift_r <= {rx_level, shift_r[7:1]};
                     if (bit_idx_r == 3'h7) begin
                        state_r <= URX_STOP;
                     end else begin
                        bit_idx_r <= bit_idx_r + 3'h1;
                     end
                  end else begin
                     cnt_r <= cnt_r + 16'h0001;
                  end
               end
               URX_STOP: begin
                  if (bit_end) begin
                     cnt_r   <= '0;
                     state_r <= URX_IDLE;
                     if (!rx_level) begin
                        byte_idx_r <= 4'h0;
                        crc_r      <= CRC_INIT;
                        err_r      <= 1'b1;
                     end else if (byte_idx_r == 4'(FRAME_BYTES-1)) begin
                        byte_idx_r <= 4'h0;
                        crc_r      <= CRC_INIT;
                        valid_r    <= (crc_r == shift_r); // [R07]
                        err_r      <= (crc_r != shift_r); // [R07]
                     end else begin
                        data_r     <= {data_r[DW-9:0], shift_r};
                        crc_r      <= hms_crc8_step(crc_r, shift_r);
                        byte_idx_r <= byte_idx_r + 4'h1;
                     end
                  end else begin
                     cnt_r <= cnt_r + 16'h0001;
                  end
               end
               default: state_r <= URX_IDLE;
            endcase
         end
      end
   end

endmodule : hms_uart_rx

// ===== verification/hms_host_if_assertions.sv
`timescale 1ns/1ps
module hms_host_if_chk
   import hms_pkg::*;
#(
   parameter logic LINK_UART_LEVEL = 1'h1
) (
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        step_dir_select,
   input wire logic        serial_config_select,
   input wire logic        link_type_select,
   input wire logic        spi_cs_n,
   input wire logic        spi_miso_oe,
   input wire logic [3:0]  mres,
   input wire logic        cfg_valid,
   input wire hms_mode_t   mode_sel,
   input wire logic        link_is_uart,
   input wire logic        ramp_gen_en,
   input wire logic        pin_config_en,
   input wire logic        host_if_en,
   input wire logic        cmd_valid,
   input wire logic        cmd_is_write,
   input wire logic [39:0] cmd_word,
   input wire logic        spi_frame_err,
   input wire logic        uart_frame_valid,
   input wire logic        uart_crc_err,
   input wire logic [9:0]  mstep_count
);
   logic [9:0] inc_w;
   assign inc_w = 10'h1 << ((mres > MRES_MAX) ? MRES_MAX : mres);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_mode_decode:
      assert property ($rose(cfg_valid) |-> mode_sel ==
         (!$past(step_dir_select) ? HMS_MODE_MOTION :
         ($past(serial_config_select) ? HMS_MODE_STEPDIR :
         HMS_MODE_STANDALONE))) else $error("mode differs from straps");
   a_link_pick:
      assert property ($rose(cfg_valid) |->
         link_is_uart == ($past(link_type_select) == LINK_UART_LEVEL))
      else $error("link choice differs from strap");
   a_cfg_wait:
      assert property ($rose(rst_n) |-> !cfg_valid ##[1:8] cfg_valid)
      else $error("straps not captured in time");
   a_straps_held:
      assert property (cfg_valid && $past(cfg_valid) |->
         $stable(mode_sel) && $stable(link_is_uart))
      else $error("captured straps moved");
   a_enable_map:
      assert property (cfg_valid |->
         ramp_gen_en == (mode_sel == HMS_MODE_MOTION) &&
         pin_config_en == (mode_sel == HMS_MODE_STANDALONE) &&
         host_if_en == (mode_sel != HMS_MODE_STANDALONE))
      else $error("enables disagree with mode");
   a_cmd_frame:
      assert property (cmd_valid |-> spi_cs_n && !$past(spi_cs_n, 6) &&
         !spi_frame_err ##1 !cmd_valid)
      else $error("command not framed by chip select");
   a_write_flag:
      assert property (cmd_valid |-> cmd_is_write == cmd_word[SPI_WR_BIT])
      else $error("write flag differs from bit 39");
   a_miso_quiet:
      assert property (spi_miso_oe |->
         cfg_valid && host_if_en && !link_is_uart)
      else $error("miso driven while port is off");
   a_motion_hold:
      assert property (mode_sel == HMS_MODE_MOTION |=> $stable(mstep_count))
      else $error("counter moved in motion mode");
   a_step_size:
      assert property ($changed(mstep_count) |->
         10'(mstep_count - $past(mstep_count)) == $past(inc_w) ||
         10'($past(mstep_count) - mstep_count) == $past(inc_w))
      else $error("step amount wrong");
   a_uart_pulse:
      assert property (uart_frame_valid |-> !uart_crc_err ##1
         !uart_frame_valid) else $error("uart result pulse wrong");
endmodule : hms_host_if_chk

// ===== verification/hms_host_if_tb.sv
`timescale 1ns/1ps
module hms_host_if_tb;
   import hms_pkg::*;
   logic        clk_sys = 1'h0, rst_n = 1'h0;
   logic        step_dir_select = 1'h1, serial_config_select = 1'h1;
   logic        link_type_select = 1'h0, uart_diff_mode = 1'h1;
   logic        step_in = 1'h0, dir_in = 1'h0, dual_edge_step = 1'h0;
   logic [3:0]  mres = 4'h0;
   logic [39:0] status_word = 40'h0, cmd_word;
   logic        spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
   logic        wire_pos, wire_neg, cfg_valid, link_is_uart;
   hms_mode_t   mode_sel;
   logic        ramp_gen_en, step_dir_en, pin_config_en, host_if_en;
   logic        cmd_valid, cmd_is_write, spi_frame_err;
   logic        uart_frame_valid, uart_crc_err, sd_r;
   logic [55:0] uart_frame_data;
   logic [15:0] uart_baud_len;
   logic [9:0]  mstep_count, exp_cnt;
   logic [63:0] exp_q[$];
   int          error_cnt = 0, tests_run = 0;

   always #50 clk_sys = ~clk_sys;

   hms_host_if #(.LINK_UART_LEVEL(1'h1), .FRAME_BYTES(8)) dut (.clk_sys,
      .rst_n, .step_dir_select, .serial_config_select, .link_type_select,
      .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe, .wire_pos,
      .wire_neg, .uart_diff_mode, .step_in, .dir_in, .dual_edge_step, .mres,
      .status_word, .cfg_valid, .mode_sel, .link_is_uart, .ramp_gen_en,
      .step_dir_en, .pin_config_en, .host_if_en, .cmd_valid, .cmd_is_write,
      .cmd_word, .spi_frame_err, .uart_frame_valid, .uart_frame_data,
      .uart_crc_err, .uart_baud_len, .mstep_count);
   hms_host_model host (.clk_sys, .spi_miso, .uart_diff_mode, .spi_sclk,
      .spi_cs_n, .spi_mosi, .wire_pos, .wire_neg);

   task automatic check(input string nm, input logic [63:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results
   task automatic drain;
      for (int n = 0; n < 2000 && exp_q.size() != 0; n++) host.hclk(1);
      if (exp_q.size() != 0) begin
         check("timeout", 64'h1, 64'h0);
         results();
      end
   endtask : drain
   task automatic boot(input logic sd, cfg, lnk);
      logic [6:0] e;
      rst_n = 1'h0;
      step_dir_select = sd;
      serial_config_select = cfg;
      link_type_select = lnk;
      sd_r = sd;
      exp_cnt = 10'h0;
      host.hclk(8);
      rst_n = 1'h1;
      for (int n = 0; n < 20 && cfg_valid !== 1'h1; n++) host.hclk(1);
      e = {sd ? (cfg ? HMS_MODE_STEPDIR : HMS_MODE_STANDALONE)
         : HMS_MODE_MOTION, lnk, !sd, sd & !cfg, !(sd & !cfg), sd};
      for (int k = 0; k < 2; k++) begin
         check("mode", {cfg_valid, mode_sel, link_is_uart, ramp_gen_en,
            pin_config_en, host_if_en, step_dir_en},
            {1'h1, e});
         step_dir_select = ~step_dir_select;
         serial_config_select = ~serial_config_select;
         link_type_select = ~link_type_select;
         host.hclk(10);
      end
   endtask : boot
   task automatic steps(input int n);
      logic       d;
      logic [9:0] inc;
      inc = 10'h1 << ((mres > MRES_MAX) ? MRES_MAX : mres);
      for (int i = 0; i < n; i++) begin
         d = 1'($urandom);
         dir_in = d;
         host.hclk(2);
         step_in = ~step_in;
         if (sd_r && (step_in || dual_edge_step)) begin
            exp_cnt = d ? exp_cnt - inc : exp_cnt + inc;
         end
         host.hclk(4);
      end
      check("mstep", mstep_count, exp_cnt);
   endtask : steps

   always @(posedge clk_sys) begin
      if (rst_n && (cmd_valid | spi_frame_err | uart_frame_valid
                    | uart_crc_err)) begin
         if (exp_q.size() == 0) begin
            check("unexpected", 64'h1, 64'h0);
         end else begin
            check("event", {cmd_valid, spi_frame_err, uart_frame_valid,
               uart_crc_err, 3'h0, cmd_valid & cmd_is_write, cmd_valid ?
               {16'h0, cmd_word} : (uart_frame_valid ? uart_frame_data
               : 56'h0)}, exp_q.pop_front());
         end
      end
   end

   initial begin
      #9000000;
      check("watchdog", 64'h1, 64'h0);
      results();
   end

   initial begin
      logic [39:0] cmd, rx;
      logic [55:0] d;
      int          nb[7] = '{40, 40, 40, 39, 40, 1, 41};
      void'($urandom(53));
      boot(1'h1, 1'h1, 1'h0);
      foreach (nb[i]) begin
         cmd = 40'({$urandom(), $urandom()});
         status_word = 40'({$urandom(), $urandom()});
         exp_q.push_back(nb[i] == 40 ? {4'h8, 3'h0, cmd[39], 16'h0, cmd}
                                     : {4'h4, 60'h0});
         host.spi_xfer(cmd, nb[i], rx);
         if (nb[i] == 40) check("miso", rx, status_word);
         drain();
      end
      for (int k = 0; k < 4; k++) begin
         mres = 4'(k * 5);
         dual_edge_step = k[0];
         steps(5);
      end
      boot(1'h1, 1'h0, 1'h0);
      host.spi_xfer(cmd, 40, rx);
      steps(6);
      boot(1'h0, 1'h1, 1'h1);
      host.spi_xfer(cmd, 40, rx);
      steps(6);
      for (int k = 0; k < 3; k++) begin
         uart_diff_mode = (k != 1);
         d = {8'h05, 48'({$urandom(), $urandom()})};
         exp_q.push_back(k == 2 ? {4'h1, 60'h0} : {4'h2, 4'h0, d});
         host.uart_frame(d, k == 2);
         drain();
         check("baud", uart_baud_len >= 16'h7 && uart_baud_len <= 16'h9,
               1'h1);
      end
      results();
   end
endmodule : hms_host_if_tb

bind hms_host_if hms_host_if_chk #(.LINK_UART_LEVEL(LINK_UART_LEVEL)) u_chk (
   .clk_sys, .rst_n, .step_dir_select, .serial_config_select,
   .link_type_select, .spi_cs_n, .spi_miso_oe, .mres, .cfg_valid, .mode_sel,
   .link_is_uart, .ramp_gen_en, .pin_config_en, .host_if_en, .cmd_valid,
   .cmd_is_write, .cmd_word, .spi_frame_err, .uart_frame_valid,
   .uart_crc_err, .mstep_count);

// ===== verification/hms_host_model.sv
`timescale 1ns/1ps
module hms_host_model #(
   parameter int BIT_CLKS = 8
) (
   input  wire logic clk_sys,
   input  wire logic spi_miso,
   input  wire logic uart_diff_mode,
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_mosi,
   output logic      wire_pos,
   output logic      wire_neg
);
   logic line_r   = 1'h1;
   logic wander_r = 1'h0;
   initial begin
      spi_sclk = 1'h1;
      spi_cs_n = 1'h1;
      spi_mosi = 1'h0;
   end
   // an open negative pin floats, so let it wander
   always @(posedge clk_sys) wander_r <= ~wander_r;
   assign wire_pos = line_r;
   assign wire_neg = uart_diff_mode ? ~line_r : wander_r;

   task automatic hclk(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : hclk
   // mode 3, miso taken on each rising sclk
   task automatic spi_xfer(input logic [39:0] cmd, input int nb,
                           output logic [39:0] rx);
      rx = 40'h0;
      spi_cs_n = 1'h0;
      hclk(4);
      for (int i = 0; i < nb; i++) begin
         spi_sclk = 1'h0;
         spi_mosi = cmd[39 - i % 40];
         hclk(4);
         spi_sclk = 1'h1;
         rx = {rx[38:0], spi_miso};
         hclk(4);
      end
      spi_cs_n = 1'h1;
      spi_mosi = ~spi_mosi;
      hclk(6);
   endtask : spi_xfer
   task automatic uart_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'h1, b, 1'h0};
      for (int i = 0; i < 10; i++) begin
         line_r = f[i];
         hclk(BIT_CLKS);
      end
   endtask : uart_byte
   // crc8 over the payload, each byte lsb first
   task automatic uart_frame(input logic [55:0] d, input logic bad);
      logic [7:0] c;
      c = 8'h00;
      for (int k = 6; k >= 0; k--) begin
         uart_byte(d[8*k +: 8]);
         for (int i = 0; i < 8; i++) begin
            c = {c[6:0], 1'h0} ^ ((c[7] ^ d[8*k+i]) ? 8'h07 : 8'h00);
         end
      end
      uart_byte(c ^ {7'h0, bad});
      hclk(40 * BIT_CLKS);
   endtask : uart_frame
endmodule : hms_host_model
